/* verilog/chip_reset_consts.svh */
`ifndef CHIP_RESET_CONSTS_SVH
`define CHIP_RESET_CONSTS_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_PS      5000
`define T_DRB_MIN_US       25000
`define T_DR_MAX_NS        90000
`define T_FRL_MIN_NS       50000
`define T_FRS_MIN_NS       2000
`define US_CYCLES(us)      (((us) * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define NS_CYCLES(ns)      (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FILT_CYCLES        4
`endif

/* verilog/chip_reset_pkg.sv */
`default_nettype none
package chip_reset_pkg;
    typedef enum logic [2:0] {
        SEQ_DESTR_BIST  = 3'h0,
        SEQ_DESTR       = 3'h1,
        SEQ_EXT_LONG    = 3'h2,
        SEQ_FUNC_LONG   = 3'h3,
        SEQ_FUNC_SHORT  = 3'h4
    } seq_kind_e;
    typedef enum logic [2:0] {
        ST_POR   = 3'h0,
        ST_RUN   = 3'h1,
        ST_FINAL = 3'h2,
        ST_BOOT  = 3'h3,
        ST_APP   = 3'h4
    } seq_state_e;
    typedef struct packed {
        logic req;
        logic long_seq;
        logic pin_drive_en;
    } func_req_s;
endpackage
`default_nettype wire

/* verilog/chip_reset_sequencer.sv */
`include "chip_reset_consts.svh"
`default_nettype none
module chip_reset_sequencer
    import chip_reset_pkg::*;
#(
    parameter int unsigned BIST_CYCLES  = `US_CYCLES(`T_DRB_MIN_US),
    parameter int unsigned DR_CYCLES    = `NS_CYCLES(`T_DR_MAX_NS) / 2,
    parameter int unsigned FRL_CYCLES   = `NS_CYCLES(`T_FRL_MIN_NS) + 2000,
    parameter int unsigned FRS_CYCLES   = `NS_CYCLES(`T_FRS_MIN_NS) + 200,
    parameter int unsigned FINAL_CYCLES = 16
) (
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      resetn,
    input  wire logic      clk_en,
    // board side
    input  wire logic      board_power_on_reset_n,
    input  wire logic      reset_pin_in,
    output logic           reset_pin_out,
    output logic           reset_pin_oe,
    // sequence selection
    input  wire logic      logic_memory_self_test,
    input  wire logic      ext_reset_req,
    input  wire func_req_s func_req,
    input  wire logic      boot_done,
    // status
    output logic           chip_reset_n,
    output logic           app_run,
    output seq_kind_e      seq_kind
);
    // ------------------------------------------------------------
    // input synchronisers and glitch filters
    // ------------------------------------------------------------
    logic [1:0] por_sync_q, pin_sync_q;
    logic [2:0] por_cnt_q, pin_cnt_q;
    logic       por_filt_q, pin_filt_q, por_prev_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            por_sync_q <= 2'h0;
            pin_sync_q <= 2'h0;
        end else if (clk_en) begin
            por_sync_q <= {por_sync_q[0], board_power_on_reset_n};
            pin_sync_q <= {pin_sync_q[0], reset_pin_in};
        end
    end
    // a level must hold for FILT_CYCLES before it counts: slow ramps bounce
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            por_cnt_q  <= 3'h0;
            pin_cnt_q  <= 3'h0;
            por_filt_q <= 1'b0;
            pin_filt_q <= 1'b0;
            por_prev_q <= 1'b0;
        end else if (clk_en) begin
            por_prev_q <= por_filt_q;
            if (por_sync_q[1] == por_filt_q) por_cnt_q <= 3'h0;
            else if (por_cnt_q == 3'(`FILT_CYCLES - 1)) begin
                por_filt_q <= por_sync_q[1];
                por_cnt_q  <= 3'h0;
            end else por_cnt_q <= por_cnt_q + 3'h1;
            if (pin_sync_q[1] == pin_filt_q) pin_cnt_q <= 3'h0;
            else if (pin_cnt_q == 3'(`FILT_CYCLES - 1)) begin
                pin_filt_q <= pin_sync_q[1];
                pin_cnt_q  <= 3'h0;
            end else pin_cnt_q <= pin_cnt_q + 3'h1;
        end
    end
    // ------------------------------------------------------------
    // sequence control
    // ------------------------------------------------------------
    seq_state_e  state_q;
    logic [31:0] cnt_q;
    logic        drive_q;
    wire         por_rise  = por_filt_q & ~por_prev_q;
    wire         start_ext = ext_reset_req;
    wire         start_fn  = func_req.req;
    wire [31:0]  run_len   =
        (seq_kind == SEQ_DESTR)      ? 32'(DR_CYCLES)  :
        (seq_kind == SEQ_FUNC_LONG)  ? 32'(FRL_CYCLES) :
        (seq_kind == SEQ_FUNC_SHORT) ? 32'(FRS_CYCLES) :
                                       32'(BIST_CYCLES);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q       <= ST_POR;
            cnt_q         <= 32'h0;
            drive_q       <= 1'b1;
            seq_kind      <= SEQ_DESTR_BIST;
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= 1'b1;
            chip_reset_n  <= 1'b0;
            app_run       <= 1'b0;
        end else if (clk_en) begin
            reset_pin_out <= 1'b0;
            case (state_q)
                ST_POR: begin
                    chip_reset_n <= 1'b0;
                    app_run      <= 1'b0;
                    reset_pin_oe <= 1'b1;
                    drive_q      <= 1'b1;
                    cnt_q        <= 32'h0;
                    if (por_rise) begin
                        seq_kind <= logic_memory_self_test ? SEQ_DESTR_BIST : SEQ_DESTR;
                        state_q  <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q >= run_len - 32'(FINAL_CYCLES)) begin
                        cnt_q   <= 32'h0;
                        state_q <= ST_FINAL;
                    end
                end
                ST_FINAL: begin
                    if (cnt_q < 32'(FINAL_CYCLES)) cnt_q <= cnt_q + 32'h1;
                    if (cnt_q >= 32'(FINAL_CYCLES) - 32'h1) begin
                        reset_pin_oe <= 1'b0;
                        // if this sequence drove the pin, wait while someone else still holds it low
                        if (pin_filt_q || !drive_q) begin
                            chip_reset_n <= 1'b1;
                            state_q      <= ST_BOOT;
                        end
                    end
                end
                ST_BOOT: begin
                    if (boot_done) begin
                        app_run <= 1'b1;
                        state_q <= ST_APP;
                    end
                end
                default: begin
                    if (start_ext || start_fn) begin
                        chip_reset_n <= 1'b0;
                        app_run      <= 1'b0;
                        cnt_q        <= 32'h0;
                        state_q      <= ST_RUN;
                        drive_q      <= start_ext | func_req.pin_drive_en;
                        reset_pin_oe <= start_ext | func_req.pin_drive_en;
                        if (start_ext) seq_kind <= SEQ_EXT_LONG;
                        else seq_kind <= func_req.long_seq ? SEQ_FUNC_LONG : SEQ_FUNC_SHORT;
                    end
                end
            endcase
            // power-on low wins over every state, but internal reset lags the board by the synchroniser and filter cycles
            if (por_filt_q == 1'b0) begin
                state_q      <= ST_POR;
                chip_reset_n <= 1'b0;
                app_run      <= 1'b0;
                reset_pin_oe <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/chip_reset_props.sv */
`default_nettype none
module chip_reset_props
    import chip_reset_pkg::*;
(
    input wire logic      core_clk, resetn, board_power_on_reset_n, reset_pin_in,
    input wire logic      reset_pin_out, reset_pin_oe, ext_reset_req, boot_done,
    input wire logic      chip_reset_n, app_run,
    input wire func_req_s func_req,
    input wire seq_kind_e seq_kind
);
    timeunit 1ns / 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ext request wins, so the functional checks look only at lone requests
    wire fq = app_run && board_power_on_reset_n && !ext_reset_req && func_req.req;
    chk_pin_low_only: assert property (reset_pin_out == 1'b0)
        else $error("reset pin value not low");
    chk_release_first: assert property ($rose(chip_reset_n) |-> !reset_pin_oe)
        else $error("internal reset released while pin pulled");
    chk_pin_extend: assert property ($rose(chip_reset_n) && seq_kind != SEQ_FUNC_SHORT
        && seq_kind != SEQ_FUNC_LONG |-> $past(reset_pin_in)) else $error("pin low ignored");
    chk_por_holds: assert property (!board_power_on_reset_n [*8]
        |-> !chip_reset_n && !app_run) else $error("power-on low did not hold reset");
    chk_app_gate: assert property ($rose(app_run) |-> $past(boot_done) && chip_reset_n)
        else $error("application ran before handover");
    chk_func_drive: assert property (fq && func_req.pin_drive_en |-> ##[1:6] reset_pin_oe)
        else $error("enabled functional reset did not pull pin");
    chk_func_quiet: assert property (fq && !func_req.pin_drive_en |=> !reset_pin_oe [*8])
        else $error("disabled functional reset pulled pin");
    chk_ext_kind: assert property (app_run && board_power_on_reset_n && ext_reset_req
        |-> ##[1:6] seq_kind == SEQ_EXT_LONG) else $error("external sequence kind wrong");
endmodule
`default_nettype wire

/* tb/reset_board_model.sv */
`default_nettype none
module reset_board_model (
    input  wire logic core_clk,
    input  wire logic supply_ok,
    input  wire logic gen_hold,
    input  wire logic reset_pin_out,
    input  wire logic reset_pin_oe,
    output var logic  board_power_on_reset_n,
    output wire logic reset_pin_in
);
    timeunit 1ns / 1ps;
    int stable_cnt = 0;
    initial board_power_on_reset_n = 1'b0;
    // pull-up wins only when no party pulls low
    assign reset_pin_in = (reset_pin_oe && !reset_pin_out) || gen_hold ? 1'b0 : 1'b1;
    always @(posedge core_clk) begin
        stable_cnt <= supply_ok ? stable_cnt + 1 : 0;
        board_power_on_reset_n <= #1 supply_ok && stable_cnt > 10;
    end
endmodule
`default_nettype wire

/* tb/chip_reset_sequencer_tb.sv */
`default_nettype none
module chip_reset_sequencer_tb;
    import chip_reset_pkg::*;
    timeunit 1ns / 1ps;
    logic      core_clk = 0, resetn = 0, supply_ok = 0, gen_hold = 0;
    logic      self_test = 0, ext_req = 0, boot_done = 0, clk_en = 1;
    func_req_s freq = '0;
    wire logic por_n, pin_in, pin_out, pin_oe, crst_n, app_run;
    seq_kind_e kind;
    int        error_cnt = 0, checks = 0;
    always #2.5 core_clk = ~core_clk;
    chip_reset_sequencer #(.BIST_CYCLES(64), .DR_CYCLES(32), .FRL_CYCLES(48),
        .FRS_CYCLES(24), .FINAL_CYCLES(16)) uut (.core_clk(core_clk), .resetn(resetn),
        .clk_en(clk_en), .board_power_on_reset_n(por_n), .reset_pin_in(pin_in),
        .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .logic_memory_self_test(self_test),
        .ext_reset_req(ext_req), .func_req(freq), .boot_done(boot_done),
        .chip_reset_n(crst_n), .app_run(app_run), .seq_kind(kind));
    reset_board_model brd (.core_clk(core_clk), .supply_ok(supply_ok), .gen_hold(gen_hold),
        .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .board_power_on_reset_n(por_n),
        .reset_pin_in(pin_in));
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // st: 0 power-on, 1 external, 2 functional; hold keeps the pin low past the final phase
    task automatic run(seq_kind_e ek, int st, bit drv, int hold);
        int n, rel, len;
        bit seen;
        n = 0; rel = 0; seen = 0;
        len = ek == SEQ_DESTR ? 32 : ek == SEQ_FUNC_LONG ? 48 : ek == SEQ_FUNC_SHORT ? 24 : 64;
        boot_done = 0;
        gen_hold = hold > 0;
        case (st)
            0: supply_ok = 1;
            1: ext_req = 1;
            default: freq = '{1'b1, ek == SEQ_FUNC_LONG, drv};
        endcase
        @(posedge core_clk) #1;
        ext_req = 0;
        freq = '0;
        if (st == 0) while (por_n !== 1) @(posedge core_clk) #1;
        while ((crst_n !== 1 || n < 4) && n < 2000) begin
            seen |= pin_oe === 1;
            if (gen_hold && pin_oe === 0 && n > 8 && --hold == 0) begin
                gen_hold = 0;
                rel = n;
            end
            @(posedge core_clk) #1;
            n++;
        end
        check("seq_kind", ek, kind);
        if (rel > 0) check("extended", 1, n > rel + 2);
        else check("length", 1, n >= len && n <= len + 14);
        check("pin pulled", drv, seen);
        check("pin released", 1, pin_in);
        check("app before boot", 0, app_run);
        repeat ($urandom % 8) @(posedge core_clk) #1;
        boot_done = 1;
        repeat (8) if (app_run !== 1) @(posedge core_clk) #1;
        check("app run", 1, app_run);
    endtask
    initial begin
        void'($urandom(42));
        repeat (6) @(posedge core_clk);
        #1 resetn = 1;
        self_test = 1;
        run(SEQ_DESTR_BIST, 0, 1, 0);
        supply_ok = 0;
        self_test = 0;
        repeat (12) @(posedge core_clk) #1;
        clk_en = 0;
        repeat (1 + $urandom % 4) @(posedge core_clk) #1;
        clk_en = 1;
        run(SEQ_DESTR, 0, 1, 0);
        run(SEQ_EXT_LONG, 1, 1, 0);
        run(SEQ_EXT_LONG, 1, 1, 10 + $urandom % 20);
        run(SEQ_FUNC_LONG, 2, 1, 0);
        run(SEQ_FUNC_LONG, 2, 0, 0);
        run(SEQ_FUNC_SHORT, 2, 1, 0);
        run(SEQ_FUNC_SHORT, 2, 0, 0);
        final_report;
    end
    initial begin
        #50us;
        error_cnt++;
        final_report;
    end
endmodule
bind chip_reset_sequencer chip_reset_props chk (.*);
`default_nettype wire
